// ===== rtl/glr_consts.vh
// constants for the pin level readback block
`ifndef GLR_CONSTS_VH
`define GLR_CONSTS_VH

// register map
`define GLR_ADDR_MAIN 8'h07
`define GLR_ADDR_AUX 8'h08
`define GLR_RESET_VAL 16'h0000

// level codes
`define GLR_CODE_LOW 2'h0
`define GLR_CODE_WEAK_LOW 2'h1
`define GLR_CODE_WEAK_HIGH 2'h2
`define GLR_CODE_HIGH 2'h3

// field low bits, main register
`define GLR_MAIN_PIN0_LSB 0
`define GLR_MAIN_PIN1_LSB 2
`define GLR_MAIN_PIN2_LSB 4
`define GLR_MAIN_PIN3_LSB 6
`define GLR_MAIN_PIN4_LSB 8
// field low bits, aux register
`define GLR_AUX_B0_LSB 0
`define GLR_AUX_B1_LSB 2
`define GLR_AUX_A0_LSB 8
`define GLR_AUX_A1_LSB 10

// duty thresholds in per mille of the period
`define GLR_PERMILLE 32'h0000_03E8
`define GLR_THR_STRONG 32'h0000_029A
`define GLR_THR_HALF 32'h0000_01F4

// timing: clock rate and static-level timeout
`define GLR_CLK_MHZ 32'h0000_0019
`define GLR_STATIC_US 32'h0000_03E8

`endif

// ===== rtl/glr_sync2.v
// two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/10ps
`default_nettype none

module glr_sync2 #(
    parameter W = 9
) (
    input wire mclk, // core clock
    input wire rst_n, // async reset, active low
    input wire [W-1:0] async_in, // raw pin levels
    output wire [W-1:0] sync_out // levels on the mclk domain
);

    // ----------------------------------------
    // synchroniser stages
    // ----------------------------------------
    reg [W-1:0] meta_q;
    reg [W-1:0] stable_q;

    // first stage is read only by the second one
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= {W{1'b0}};
            stable_q <= {W{1'b0}};
        end
        else
        begin
            meta_q <= async_in;
            stable_q <= meta_q;
        end
    end

    assign sync_out = stable_q;

endmodule
`default_nettype wire

// ===== rtl/glr_duty_class.v
// duty ratio classifier: high and total cycle counts to a level code
`timescale 1ns/10ps
`default_nettype none
`include "glr_consts.vh"

module glr_duty_class #(
    parameter CW = 16
) (
    input wire [CW-1:0] high_cnt, // cycles high in the last period
    input wire [CW-1:0] total_cnt, // cycles in the last period
    output reg [1:0] code // level code for that period
);

    // ----------------------------------------
    // scaled comparisons
    // ----------------------------------------
    // scaling by 1000 keeps 66.6% exact without a divider
    wire [CW-1:0] low_cnt;
    wire [31:0] low_pm;
    wire [31:0] high_pm;
    wire [31:0] tot_strong;
    wire [31:0] tot_half;

    assign low_cnt = total_cnt - high_cnt;
    assign low_pm = {{(32-CW){1'b0}}, low_cnt} * `GLR_PERMILLE;
    assign high_pm = {{(32-CW){1'b0}}, high_cnt} * `GLR_PERMILLE;
    assign tot_strong = {{(32-CW){1'b0}}, total_cnt} * `GLR_THR_STRONG;
    assign tot_half = {{(32-CW){1'b0}}, total_cnt} * `GLR_THR_HALF;

    // low side checked first, so exactly 50% reads weak low
    always @*
    begin
        if (low_pm > tot_strong)
            code = `GLR_CODE_LOW;
        else if (low_pm >= tot_half)
            code = `GLR_CODE_WEAK_LOW;
        else if (high_pm > tot_strong)
            code = `GLR_CODE_HIGH;
        else
            code = `GLR_CODE_WEAK_HIGH;
    end

endmodule
`default_nettype wire

// ===== rtl/glr_top.v
// pin level readback: per-pin duty classification and two read-only registers
//
// How it works
// - every monitored pin has a read-only 2-bit code taken from the pin itself, input or output.
// - code 00 means static low or a waveform low for more than 66.6% of its period.
// - code 01 means a waveform low for at least 50% and at most 66.6% of its period.
// - code 10 means a waveform high for more than 50% and at most 66.6% of its period.
// - code 11 means static high or a waveform high for more than 66.6% of its period.
// - the main register holds pins 4..0 in bits 9:8 down to 1:0, bits 15:10 read zero.
// - the aux register holds 1A, 0A, 1B, 0B in 11:10, 9:8, 3:2, 1:0, others read zero.
// - reserved bits always read zero and writes to either register change nothing.
// - the aux register sits at 08h and resets to 0000h with every code at 00.
// - the main register sits at 07h and resets to 0000h.
`timescale 1ns/10ps
`default_nettype none
`include "glr_consts.vh"

module glr_top #(
    parameter CW = 16,
    parameter STATIC_CYCLES = `GLR_STATIC_US * `GLR_CLK_MHZ
) (
    input wire mclk, // 25 MHz core clock
    input wire rst_n, // async reset, active low
    input wire general_pin_zero, // monitored pin 0
    input wire general_pin_one, // monitored pin 1
    input wire general_pin_two, // monitored pin 2
    input wire general_pin_three, // monitored pin 3
    input wire general_pin_four, // monitored pin 4
    input wire side_a_pin_zero, // monitored pin 0A
    input wire side_a_pin_one, // monitored pin 1A
    input wire side_b_pin_zero, // monitored pin 0B
    input wire side_b_pin_one, // monitored pin 1B
    input wire [7:0] reg_addr, // register address from the host interface
    input wire reg_rd, // read strobe, one cycle
    input wire reg_wr, // write strobe, one cycle
    input wire [15:0] reg_wdata, // write data
    output reg [15:0] reg_rdata, // read data, held until next read
    output reg reg_rvalid // read data valid, one cycle
);

    localparam NPIN = 9;
    // full-width count first, then cut to the counter width on purpose
    localparam [31:0] STATIC_LAST_W = STATIC_CYCLES - 1;
    localparam [CW-1:0] STATIC_LAST = STATIC_LAST_W[CW-1:0];

    // ----------------------------------------
    // pin gathering and synchronisation
    // ----------------------------------------
    // index order: 0..4 main pins, 5 = 0A, 6 = 1A, 7 = 0B, 8 = 1B
    wire [NPIN-1:0] pins_raw;
    wire [NPIN-1:0] pins_s;
    wire [2*NPIN-1:0] codes;

    assign pins_raw = {side_b_pin_one, side_b_pin_zero, side_a_pin_one, side_a_pin_zero,
                       general_pin_four, general_pin_three, general_pin_two,
                       general_pin_one, general_pin_zero};

    // the pad level is sampled whatever the pin direction
    glr_sync2 #(
        .W(NPIN)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    // ----------------------------------------
    // per-pin period measurement
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1)
        begin : g_pin
            reg prev_q;
            reg [CW-1:0] high_q;
            reg [CW-1:0] high_d;
            reg [CW-1:0] total_q;
            reg [CW-1:0] total_d;
            reg valid_q;
            reg valid_d;
            reg [1:0] code_q;
            reg [1:0] code_d;
            wire rise;
            wire [1:0] class_code;

            assign rise = pins_s[gi] & ~prev_q;

            // ratio of the period just closed
            glr_duty_class #(
                .CW(CW)
            ) u_class (
                .high_cnt(high_q),
                .total_cnt(total_q),
                .code(class_code)
            );

            // a period runs from one rising edge to the next; a pin with no
            // rising edge for STATIC_CYCLES is taken as static and reports its level
            always @*
            begin
                high_d = high_q + {{(CW-1){1'b0}}, pins_s[gi]};
                total_d = total_q + {{(CW-1){1'b0}}, 1'b1};
                valid_d = valid_q;
                code_d = code_q;
                if (rise)
                begin
                    // first edge after a static spell only opens a period
                    if (valid_q)
                        code_d = class_code;
                    high_d = {{(CW-1){1'b0}}, 1'b1};
                    total_d = {{(CW-1){1'b0}}, 1'b1};
                    valid_d = 1'b1;
                end
                else if (total_q == STATIC_LAST)
                begin
                    code_d = pins_s[gi] ? `GLR_CODE_HIGH : `GLR_CODE_LOW;
                    high_d = {CW{1'b0}};
                    total_d = {CW{1'b0}};
                    valid_d = 1'b0;
                end
            end

            // codes start at low until the first measurement
            always @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    prev_q <= 1'b0;
                    high_q <= {CW{1'b0}};
                    total_q <= {CW{1'b0}};
                    valid_q <= 1'b0;
                    code_q <= `GLR_CODE_LOW;
                end
                else
                begin
                    prev_q <= pins_s[gi];
                    high_q <= high_d;
                    total_q <= total_d;
                    valid_q <= valid_d;
                    code_q <= code_d;
                end
            end

            assign codes[2*gi+1:2*gi] = code_q;
        end
    endgenerate

    // ----------------------------------------
    // register images
    // ----------------------------------------
    // reserved fields are hard zero, so no storage can ever leak into them
    reg [15:0] main_img;
    reg [15:0] aux_img;

    always @*
    begin
        main_img = `GLR_RESET_VAL;
        main_img[`GLR_MAIN_PIN0_LSB+1:`GLR_MAIN_PIN0_LSB] = codes[1:0];
        main_img[`GLR_MAIN_PIN1_LSB+1:`GLR_MAIN_PIN1_LSB] = codes[3:2];
        main_img[`GLR_MAIN_PIN2_LSB+1:`GLR_MAIN_PIN2_LSB] = codes[5:4];
        main_img[`GLR_MAIN_PIN3_LSB+1:`GLR_MAIN_PIN3_LSB] = codes[7:6];
        main_img[`GLR_MAIN_PIN4_LSB+1:`GLR_MAIN_PIN4_LSB] = codes[9:8];
        aux_img = `GLR_RESET_VAL;
        aux_img[`GLR_AUX_A0_LSB+1:`GLR_AUX_A0_LSB] = codes[11:10];
        aux_img[`GLR_AUX_A1_LSB+1:`GLR_AUX_A1_LSB] = codes[13:12];
        aux_img[`GLR_AUX_B0_LSB+1:`GLR_AUX_B0_LSB] = codes[15:14];
        aux_img[`GLR_AUX_B1_LSB+1:`GLR_AUX_B1_LSB] = codes[17:16];
    end

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    // writes are accepted on the port but never reach any state
    wire wr_ignored;
    assign wr_ignored = reg_wr & (|reg_wdata) & 1'b0;

    // read data registered one cycle after the strobe; other addresses read zero
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= `GLR_RESET_VAL;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd | wr_ignored;
            if (reg_rd)
            begin
                case (reg_addr)
                    `GLR_ADDR_MAIN: reg_rdata <= main_img;
                    `GLR_ADDR_AUX: reg_rdata <= aux_img;
                    default: reg_rdata <= `GLR_RESET_VAL;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ===== dv/glr_chk.sv
// assertions on the ports of the pin level readback block
`timescale 1ns/10ps
`default_nettype none
module glr_chk #(
    parameter STATIC_CYCLES = 64
) (
    input wire logic mclk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic general_pin_zero, // pin 0
    input wire logic side_b_pin_zero, // pin 0B
    input wire logic [7:0] reg_addr, // address
    input wire logic reg_rd, // read strobe
    input wire logic [15:0] reg_rdata, // read data
    input wire logic reg_rvalid // read valid
);
    localparam int SETTLE = STATIC_CYCLES + 16;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [15:0] low_run_q;
    logic [15:0] high_run_q;
    // ----------------------------------------
    // static run lengths
    // ----------------------------------------
    // saturating, so a long static level never wraps back to zero
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_run_q <= 16'h0000;
            high_run_q <= 16'h0000;
        end
        else
        begin
            low_run_q <= general_pin_zero ? 16'h0000 : low_run_q + {15'h0, ~&low_run_q};
            high_run_q <= side_b_pin_zero ? high_run_q + {15'h0, ~&high_run_q} : 16'h0000;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence s_read(a);
        reg_rd && reg_addr == a;
    endsequence
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_no_stray_valid: assert property (!reg_rd |=> !reg_rvalid)
        else $error("valid without read");
    a_main_resv_zero: assert property (s_read(8'h07) |=> reg_rdata[15:10] == 6'h00)
        else $error("main reserved bits set");
    a_aux_resv_zero: assert property (s_read(8'h08) |=>
        reg_rdata[15:12] == 4'h0 && reg_rdata[7:4] == 4'h0) else $error("aux reserved set");
    a_unmapped_zero: assert property (reg_rd && reg_addr != 8'h07 && reg_addr != 8'h08
        |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_static_low_code: assert property (s_read(8'h07) ##0 low_run_q >= SETTLE
        |=> reg_rdata[1:0] == 2'h0) else $error("static low code wrong");
    a_static_high_code: assert property (s_read(8'h08) ##0 high_run_q >= SETTLE
        |=> reg_rdata[1:0] == 2'h3) else $error("static high code wrong");
endmodule
bind glr_top glr_chk #(.STATIC_CYCLES(STATIC_CYCLES)) u_chk (.mclk(mclk), .rst_n(rst_n),
    .general_pin_zero(general_pin_zero), .side_b_pin_zero(side_b_pin_zero),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
`default_nettype wire

// ===== dv/glr_host.sv
// host model issuing register reads and writes
`timescale 1ns/10ps
`default_nettype none
module glr_host (
    input wire logic mclk, // core clock
    output logic [7:0] reg_addr = 8'h00, // address
    output logic reg_rd = 1'b0, // read strobe
    output logic reg_wr = 1'b0, // write strobe
    output logic [15:0] reg_wdata = 16'h0000, // write data
    input wire logic [15:0] reg_rdata, // read data
    input wire logic reg_rvalid // read valid
);
    // one-cycle read; a released address shows its inverse, not the old value
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output bit ok);
        int i;
        begin
            ok = 0;
            d = 16'h0000;
            @(posedge mclk);
            #1;
            reg_addr = a;
            reg_rd = 1'b1;
            @(posedge mclk);
            #1;
            reg_rd = 1'b0;
            reg_addr = ~a;
            for (i = 0; i < 4 && !ok; i++)
            begin
                if (reg_rvalid === 1'b1)
                begin
                    ok = 1;
                    d = reg_rdata;
                end
                else
                begin
                    @(posedge mclk);
                    #1;
                end
            end
        end
    endtask
    // one-cycle write
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        begin
            @(posedge mclk);
            #1;
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(posedge mclk);
            #1;
            reg_wr = 1'b0;
            reg_wdata = ~d;
        end
    endtask
endmodule
`default_nettype wire

// ===== dv/gpio_level_readback_tb.sv
// testbench for the pin level readback block
`timescale 1ns/10ps
`default_nettype none
`include "glr_consts.vh"
`define GLR_CMP(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module gpio_level_readback_tb;
    localparam int SC = 64;
    localparam int T = 12;
    typedef struct {int hi; logic [1:0] code;} glr_row_t;
    glr_row_t rows [7] = '{'{0, 2'h0}, '{3, 2'h0}, '{4, 2'h0}, '{6, 2'h1}, '{7, 2'h2},
        '{8, 2'h3}, '{12, 2'h3}};
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [8:0] pin = 9'h000;
    int hi [9] = '{default: 0};
    int pcnt = 0;
    int n_mismatch = 0;
    int total_checks = 0;
    wire [7:0] reg_addr;
    wire reg_rd;
    wire reg_wr;
    wire [15:0] reg_wdata;
    wire [15:0] reg_rdata;
    wire reg_rvalid;
    always #20 mclk = ~mclk;
    // pwm source: pin i high for hi[i] of every T cycles
    always @(posedge mclk)
    begin
        #1;
        pcnt = (pcnt + 1) % T;
        for (int i = 0; i < 9; i++)
            pin[i] = (pcnt < hi[i]);
    end
    glr_top #(.STATIC_CYCLES(SC)) DUT (.mclk(mclk), .rst_n(rst_n), .general_pin_zero(pin[0]),
        .general_pin_one(pin[1]), .general_pin_two(pin[2]), .general_pin_three(pin[3]),
        .general_pin_four(pin[4]), .side_a_pin_zero(pin[5]), .side_a_pin_one(pin[6]),
        .side_b_pin_zero(pin[7]), .side_b_pin_one(pin[8]), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));
    glr_host u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    task automatic give_verdict();
        begin
            if (n_mismatch == 0 && total_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // read and compare; a missing answer ends the run
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        bit ok;
        begin
            u_host.rd(a, d, ok);
            if (!ok)
            begin
                n_mismatch++;
                give_verdict();
            end
            `GLR_CMP(d, e)
        end
    endtask
    initial
    begin
        logic [1:0] c [9];
        repeat (20) @(posedge mclk);
        #1 rst_n = 1'b1;
        rdc(`GLR_ADDR_MAIN, `GLR_RESET_VAL);
        rdc(`GLR_ADDR_AUX, `GLR_RESET_VAL);
        // rotate the rows so every field sees every code
        for (int r = 0; r < 7; r++)
        begin
            for (int i = 0; i < 9; i++)
            begin
                hi[i] = rows[(i + r) % 7].hi;
                c[i] = rows[(i + r) % 7].code;
            end
            repeat (100) @(posedge mclk);
            rdc(8'h07, {6'h00, c[4], c[3], c[2], c[1], c[0]});
            rdc(8'h08, {4'h0, c[6], c[5], 4'h0, c[8], c[7]});
        end
        // writes of all ones change nothing
        u_host.wr(8'h07, 16'hffff);
        u_host.wr(8'h08, 16'hffff);
        rdc(8'h07, {6'h00, c[4], c[3], c[2], c[1], c[0]});
        rdc(8'h08, {4'h0, c[6], c[5], 4'h0, c[8], c[7]});
        rdc(8'h09, 16'h0000);
        // mid-run reset with pins toggling clears every code
        @(posedge mclk);
        #1 rst_n = 1'b0;
        repeat (3) @(posedge mclk);
        #1 rst_n = 1'b1;
        rdc(8'h07, 16'h0000);
        rdc(8'h08, 16'h0000);
        give_verdict();
    end
endmodule
`default_nettype wire
